// ---- logic/ssp_pkg.sv ----
package ssp_pkg;
  // ---------------------------------------------------------------
  // register offsets (word index on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [3:0] SSP_OFF_MODE = 4'h0;
  localparam logic [3:0] SSP_OFF_DRIVE = 4'h1;
  localparam logic [3:0] SSP_OFF_ENTRY = 4'h2;
  localparam logic [3:0] SSP_OFF_LOOP = 4'h3;
  localparam logic [3:0] SSP_OFF_NODE = 4'h4;
  localparam logic [3:0] SSP_OFF_RATE = 4'h5;
  localparam logic [3:0] SSP_OFF_FRAME = 4'h6;
  localparam logic [3:0] SSP_OFF_LDIR = 4'h7;
  localparam logic [3:0] SSP_OFF_CDIR = 4'h8;
  localparam logic [3:0] SSP_OFF_COFS = 4'h9;
  localparam logic [3:0] SSP_OFF_CGAIN = 4'hA;
  localparam logic [3:0] SSP_OFF_TOFS = 4'hB;
  localparam logic [3:0] SSP_OFF_FGAIN = 4'hC;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] SSP_RST_MODE = 2'h1;
  localparam logic [1:0] SSP_RST_DRIVE = 2'h1;
  localparam logic SSP_RST_ENTRY = 1'b0;
  localparam logic SSP_RST_LOOP = 1'b1;
  localparam logic SSP_RST_DIR = 1'b0;
  localparam logic [6:0] SSP_RST_NODE = 7'h0B;
  localparam logic [2:0] SSP_RST_RATE = 3'h0;
  localparam logic [3:0] SSP_RST_FRAME = 4'h0;
  localparam logic [7:0] SSP_RST_OFS = 8'h00;
  localparam logic [15:0] SSP_RST_CGAIN = 16'h0000;
  localparam logic [19:0] SSP_RST_FGAIN = 20'h00000;
  // ---------------------------------------------------------------
  // legal ranges
  // ---------------------------------------------------------------
  localparam logic [6:0] SSP_NODE_MIN = 7'h0B;
  localparam logic [6:0] SSP_NODE_MAX = 7'h63;
  localparam logic [2:0] SSP_RATE_MAX = 3'h6;
  localparam logic [3:0] SSP_FRAME_MAX = 4'h9;
  localparam logic signed [7:0] SSP_OFS_MIN = 8'sh9D;
  localparam logic signed [7:0] SSP_OFS_MAX = 8'sh63;
  localparam logic [19:0] SSP_FGAIN_MAX = 20'hF423F;
  localparam logic [1:0] SSP_MODE_LEN = 2'h1;
  localparam logic [1:0] SSP_MODE_MARK = 2'h2;
  localparam logic [1:0] SSP_DRV_4Q = 2'h1;
  localparam logic [1:0] SSP_DRV_1Q = 2'h2;
  // ---------------------------------------------------------------
  // decoded settings carried to the rest of the controller
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SSP_PAR_EVEN, SSP_PAR_ODD, SSP_PAR_NONE}
    ssp_parity_e;
  typedef struct packed {
    logic eight_bits;
    ssp_parity_e parity;
    logic two_stop;
  } ssp_frame_s;
  typedef struct packed {
    logic mark_mode;
    logic four_quadrant;
    logic binary_entry;
    logic loop_on;
    logic line_ccw;
    logic carriage_ccw;
  } ssp_ctrl_s;
endpackage

// ---- logic/ssp_bank.sv ----
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module ssp_bank (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output ssp_pkg::ssp_ctrl_s ctrl,
  output ssp_pkg::ssp_frame_s frame,
  output logic [6:0] node_number,
  output logic [17:0] baud_rate,
  output logic signed [7:0] corr_offset_mv,
  output logic [15:0] corr_gain,
  output logic signed [7:0] total_offset_mv,
  output logic [19:0] ff_gain
);
  import ssp_pkg::*;

  // ---------------------------------------------------------------
  // setting storage
  // ---------------------------------------------------------------
  logic [1:0] mode_q, mode_d;
  logic [1:0] drive_q, drive_d;
  logic entry_q, entry_d;
  logic loop_q, loop_d;
  logic [6:0] node_q, node_d;
  logic [2:0] rate_q, rate_d;
  logic [3:0] frame_q, frame_d;
  logic ldir_q, ldir_d;
  logic cdir_q, cdir_d;
  logic [7:0] cofs_q, cofs_d;
  logic [15:0] cgain_q, cgain_d;
  logic [7:0] tofs_q, tofs_d;
  logic [19:0] fgain_q, fgain_d;
  logic [31:0] rdata_q, rdata_d;
  logic signed [7:0] wofs;
  logic ok_mode;
  logic ok_drive;
  logic ok_bit;
  logic ok_node;
  logic ok_rate;
  logic ok_frame;
  logic ok_ofs;
  logic ok_cgain;
  logic ok_fgain;
  ssp_ctrl_s ctrl_q, ctrl_d;
  ssp_frame_s fdec_q, fdec_d;
  logic [17:0] baud_q, baud_d;

  // ---------------------------------------------------------------
  // write legality: any bit above the field width makes a code illegal, except sign copies above an offset
  // ---------------------------------------------------------------
  always_comb begin
    wofs = reg_wdata[7:0];
    ok_mode = (reg_wdata == {30'h0, SSP_MODE_LEN}) ||
      (reg_wdata == {30'h0, SSP_MODE_MARK});
    ok_drive = (reg_wdata == {30'h0, SSP_DRV_4Q}) ||
      (reg_wdata == {30'h0, SSP_DRV_1Q});
    ok_bit = (reg_wdata[31:1] == 31'h0);
    ok_node = (reg_wdata[31:7] == 25'h0) &&
      (reg_wdata[6:0] >= SSP_NODE_MIN) && (reg_wdata[6:0] <= SSP_NODE_MAX);
    ok_rate = (reg_wdata[31:3] == 29'h0) && (reg_wdata[2:0] <= SSP_RATE_MAX);
    ok_frame = (reg_wdata[31:4] == 28'h0) &&
      (reg_wdata[3:0] <= SSP_FRAME_MAX);
    // offsets are sign-extended 8-bit values in the low byte
    ok_ofs = (reg_wdata[31:8] == {24{reg_wdata[7]}}) &&
      (wofs >= SSP_OFS_MIN) && (wofs <= SSP_OFS_MAX);
    ok_cgain = (reg_wdata[31:16] == 16'h0);
    // gain above the top of its range is refused, not clipped
    ok_fgain = (reg_wdata[31:20] == 12'h0) &&
      (reg_wdata[19:0] <= SSP_FGAIN_MAX);
  end

  // ---------------------------------------------------------------
  // next values: a write lands only when its code is legal
  // ---------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    drive_d = drive_q;
    entry_d = entry_q;
    loop_d = loop_q;
    node_d = node_q;
    rate_d = rate_q;
    frame_d = frame_q;
    ldir_d = ldir_q;
    cdir_d = cdir_q;
    cofs_d = cofs_q;
    cgain_d = cgain_q;
    tofs_d = tofs_q;
    fgain_d = fgain_q;
    if (reg_wr) begin
      if (reg_addr == SSP_OFF_MODE) begin
        if (ok_mode) begin
          mode_d = reg_wdata[1:0];
        end
      end else if (reg_addr == SSP_OFF_DRIVE) begin
        if (ok_drive) begin
          drive_d = reg_wdata[1:0];
        end
      end else if (reg_addr == SSP_OFF_ENTRY) begin
        if (ok_bit) begin
          entry_d = reg_wdata[0];
        end
      end else if (reg_addr == SSP_OFF_LOOP) begin
        if (ok_bit) begin
          loop_d = reg_wdata[0];
        end
      end else if (reg_addr == SSP_OFF_NODE) begin
        if (ok_node) begin
          node_d = reg_wdata[6:0];
        end
      end else if (reg_addr == SSP_OFF_RATE) begin
        if (ok_rate) begin
          rate_d = reg_wdata[2:0];
        end
      end else if (reg_addr == SSP_OFF_FRAME) begin
        if (ok_frame) begin
          frame_d = reg_wdata[3:0];
        end
      end else if (reg_addr == SSP_OFF_LDIR) begin
        if (ok_bit) begin
          ldir_d = reg_wdata[0];
        end
      end else if (reg_addr == SSP_OFF_CDIR) begin
        if (ok_bit) begin
          cdir_d = reg_wdata[0];
        end
      end else if (reg_addr == SSP_OFF_COFS) begin
        if (ok_ofs) begin
          cofs_d = reg_wdata[7:0];
        end
      end else if (reg_addr == SSP_OFF_CGAIN) begin
        if (ok_cgain) begin
          cgain_d = reg_wdata[15:0];
        end
      end else if (reg_addr == SSP_OFF_TOFS) begin
        if (ok_ofs) begin
          tofs_d = reg_wdata[7:0];
        end
      end else if (reg_addr == SSP_OFF_FGAIN) begin
        if (ok_fgain) begin
          fgain_d = reg_wdata[19:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // setting registers, loaded with the factory values by reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= SSP_RST_MODE;
      drive_q <= SSP_RST_DRIVE;
      entry_q <= SSP_RST_ENTRY;
      loop_q <= SSP_RST_LOOP;
      node_q <= SSP_RST_NODE;
      rate_q <= SSP_RST_RATE;
      frame_q <= SSP_RST_FRAME;
      ldir_q <= SSP_RST_DIR;
      cdir_q <= SSP_RST_DIR;
      cofs_q <= SSP_RST_OFS;
      cgain_q <= SSP_RST_CGAIN;
      tofs_q <= SSP_RST_OFS;
      fgain_q <= SSP_RST_FGAIN;
    end else begin
      mode_q <= mode_d;
      drive_q <= drive_d;
      entry_q <= entry_d;
      loop_q <= loop_d;
      node_q <= node_d;
      rate_q <= rate_d;
      frame_q <= frame_d;
      ldir_q <= ldir_d;
      cdir_q <= cdir_d;
      cofs_q <= cofs_d;
      cgain_q <= cgain_d;
      tofs_q <= tofs_d;
      fgain_q <= fgain_d;
    end
  end

  // ---------------------------------------------------------------
  // read port: data valid only in the cycle after the strobe
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0;
    if (reg_rd) begin
      if (reg_addr == SSP_OFF_MODE) begin
        rdata_d = {30'h0, mode_q};
      end else if (reg_addr == SSP_OFF_DRIVE) begin
        rdata_d = {30'h0, drive_q};
      end else if (reg_addr == SSP_OFF_ENTRY) begin
        rdata_d = {31'h0, entry_q};
      end else if (reg_addr == SSP_OFF_LOOP) begin
        rdata_d = {31'h0, loop_q};
      end else if (reg_addr == SSP_OFF_NODE) begin
        rdata_d = {25'h0, node_q};
      end else if (reg_addr == SSP_OFF_RATE) begin
        rdata_d = {29'h0, rate_q};
      end else if (reg_addr == SSP_OFF_FRAME) begin
        rdata_d = {28'h0, frame_q};
      end else if (reg_addr == SSP_OFF_LDIR) begin
        rdata_d = {31'h0, ldir_q};
      end else if (reg_addr == SSP_OFF_CDIR) begin
        rdata_d = {31'h0, cdir_q};
      end else if (reg_addr == SSP_OFF_COFS) begin
        rdata_d = {{24{cofs_q[7]}}, cofs_q};
      end else if (reg_addr == SSP_OFF_CGAIN) begin
        rdata_d = {16'h0, cgain_q};
      end else if (reg_addr == SSP_OFF_TOFS) begin
        rdata_d = {{24{tofs_q[7]}}, tofs_q};
      end else if (reg_addr == SSP_OFF_FGAIN) begin
        rdata_d = {12'h0, fgain_q};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // decoded settings, worked out from the next values so that they
  // change at the same edge as the registers they come from
  // ---------------------------------------------------------------
  function automatic ssp_ctrl_s dec_ctrl(
    input logic [1:0] mode,
    input logic [1:0] drive,
    input logic entry,
    input logic loop,
    input logic ldir,
    input logic cdir
  );
    ssp_ctrl_s c;
    c.mark_mode = (mode == SSP_MODE_MARK);
    c.four_quadrant = (drive == SSP_DRV_4Q);
    c.binary_entry = entry;
    c.loop_on = loop;
    c.line_ccw = ldir;
    c.carriage_ccw = cdir;
    return c;
  endfunction

  function automatic ssp_frame_s dec_frame(
    input logic [3:0] code
  );
    ssp_frame_s f;
    // codes 0..5 are seven bits, parity pairs e/o/n with 1 then 2 stops
    f.eight_bits = (code >= 4'h6);
    f.two_stop = 1'b0;
    f.parity = SSP_PAR_NONE;
    case (code)
      4'h0: f.parity = SSP_PAR_EVEN;
      4'h1: begin
        f.parity = SSP_PAR_EVEN;
        f.two_stop = 1'b1;
      end
      4'h2: f.parity = SSP_PAR_ODD;
      4'h3: begin
        f.parity = SSP_PAR_ODD;
        f.two_stop = 1'b1;
      end
      4'h4: f.parity = SSP_PAR_NONE;
      4'h5: f.two_stop = 1'b1;
      4'h6: f.parity = SSP_PAR_EVEN;
      4'h7: begin
        f.parity = SSP_PAR_ODD;
        f.two_stop = 1'b1;
      end
      4'h8: f.parity = SSP_PAR_NONE;
      4'h9: f.two_stop = 1'b1;
      default: f.parity = SSP_PAR_NONE;
    endcase
    return f;
  endfunction

  function automatic logic [17:0] dec_baud(
    input logic [2:0] code
  );
    logic [17:0] b;
    case (code)
      3'h0: b = 18'h02580;
      3'h1: b = 18'h012C0;
      3'h2: b = 18'h00960;
      3'h3: b = 18'h004B0;
      3'h4: b = 18'h00258;
      3'h5: b = 18'h04B00;
      // code 7 never reaches the register, so 6 takes the rest
      default: b = 18'h09600;
    endcase
    return b;
  endfunction

  always_comb begin
    ctrl_d = dec_ctrl(mode_d, drive_d, entry_d, loop_d, ldir_d, cdir_d);
    fdec_d = dec_frame(frame_d);
    baud_d = dec_baud(rate_d);
  end

  // reset loads the decode of the factory values, so no step follows it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= dec_ctrl(SSP_RST_MODE, SSP_RST_DRIVE, SSP_RST_ENTRY,
        SSP_RST_LOOP, SSP_RST_DIR, SSP_RST_DIR);
      fdec_q <= dec_frame(SSP_RST_FRAME);
      baud_q <= dec_baud(SSP_RST_RATE);
    end else begin
      ctrl_q <= ctrl_d;
      fdec_q <= fdec_d;
      baud_q <= baud_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata = rdata_q;
  assign ctrl = ctrl_q;
  assign frame = fdec_q;
  assign baud_rate = baud_q;
  assign node_number = node_q;
  assign corr_offset_mv = cofs_q;
  assign corr_gain = cgain_q;
  assign total_offset_mv = tofs_q;
  assign ff_gain = fgain_q;
endmodule

// ---- verif/ssp_host_model.sv ----
`timescale 1ns/1ps
// host side of the serial link: bits per character it must expect
module ssp_host_model (
  input wire ssp_pkg::ssp_frame_s frame,
  output logic [3:0] char_bits
);
  import ssp_pkg::*;
  // start bit, data bits, optional parity, one or two stop bits
  always_comb begin
    char_bits = 4'h1 + (frame.eight_bits ? 4'h8 : 4'h7) +
      {3'h0, frame.parity != SSP_PAR_NONE} +
      (frame.two_stop ? 4'h2 : 4'h1);
  end
endmodule

// ---- verif/ssp_bank_chk.sv ----
`timescale 1ns/1ps
module ssp_bank_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire ssp_pkg::ssp_ctrl_s ctrl,
  input wire logic [6:0] node_number,
  input wire logic [17:0] baud_rate,
  input wire logic signed [7:0] total_offset_mv
);
  import ssp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr(logic [3:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_rd(logic [3:0] a);
    reg_rd && reg_addr == a;
  endsequence
  property p_mode;
    s_wr(SSP_OFF_MODE) ##0 reg_wdata == 32'h2 |=> ctrl.mark_mode;
  endproperty
  a_mode: assert property (p_mode) else $error("mode not decoded");
  property p_drive;
    s_wr(SSP_OFF_DRIVE) ##0 reg_wdata == 32'h2 |=> !ctrl.four_quadrant;
  endproperty
  a_drive: assert property (p_drive) else $error("drive wrong");
  property p_loop;
    s_wr(SSP_OFF_LOOP) ##0 reg_wdata == 32'h0 ##1
      !(reg_wr && reg_addr == SSP_OFF_LOOP) |-> !ctrl.loop_on [*2];
  endproperty
  a_loop: assert property (p_loop) else $error("loop still on");
  property p_node_rd;
    s_rd(SSP_OFF_NODE) |=> reg_rdata == {25'h0, $past(node_number)};
  endproperty
  a_node_rd: assert property (p_node_rd) else $error("node read");
  property p_node_ok;
    s_wr(SSP_OFF_NODE) ##0 (reg_wdata >= 32'hB && reg_wdata <= 32'h63)
      |=> {25'h0, node_number} == $past(reg_wdata);
  endproperty
  a_node_ok: assert property (p_node_ok) else $error("node write");
  property p_node_bad;
    s_wr(SSP_OFF_NODE) ##0 (reg_wdata < 32'hB || reg_wdata > 32'h63)
      |=> $stable(node_number);
  endproperty
  a_node_bad: assert property (p_node_bad) else $error("node taken");
  property p_rate;
    s_wr(SSP_OFF_RATE) ##0 reg_wdata == 32'h6 |=> baud_rate == 18'h09600;
  endproperty
  a_rate: assert property (p_rate) else $error("rate wrong");
  property p_tofs;
    s_wr(SSP_OFF_TOFS) ##0 reg_wdata == 32'hFFFFFF9D
      |=> total_offset_mv == 8'sh9D;
  endproperty
  a_tofs: assert property (p_tofs) else $error("offset wrong");
endmodule
bind ssp_bank ssp_bank_chk i_ssp_bank_chk (.clk, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ctrl, .node_number,
  .baud_rate, .total_offset_mv);

// ---- verif/test_shear_setup_parameter_bank.sv ----
`timescale 1ns/1ps
module test_shear_setup_parameter_bank;
  import ssp_pkg::*;
  logic clk, sys_rst, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  ssp_ctrl_s ctrl;
  ssp_frame_s frame;
  logic [6:0] node_number;
  logic [17:0] baud_rate;
  logic signed [7:0] corr_offset_mv, total_offset_mv;
  logic [15:0] corr_gain;
  logic [19:0] ff_gain;
  logic [3:0] char_bits;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] rst_t [13] = '{32'h1, 32'h1, 32'h0, 32'h1, 32'hB, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] baud_t [7] = '{32'h2580, 32'h12C0, 32'h960, 32'h4B0,
    32'h258, 32'h4B00, 32'h9600};
  logic [31:0] frm_t [10] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h5,
    32'h8, 32'hB, 32'hC, 32'hD};
  logic [31:0] bits_t [10] = '{32'hA, 32'hB, 32'hA, 32'hB, 32'h9, 32'hA,
    32'hB, 32'hC, 32'hA, 32'hB};
  ssp_bank i_ssp_bank (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ctrl, .frame, .node_number, .baud_rate,
    .corr_offset_mv, .corr_gain, .total_offset_mv, .ff_gain);
  ssp_host_model i_ssp_host_model (.frame, .char_bits);
  always #50 clk = ~clk;
  // ---------------------------------------------------------------
  // bus tasks; one idle cycle after a write keeps strobes apart
  // ---------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("rdata", e, reg_rdata);
    @(negedge clk);
    chk("rdata idle", 32'h0, reg_rdata);
    @(posedge clk);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog: a hung run counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    wrap_up;
  end
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 13; i++) rd(i[3:0], rst_t[i]);
    wr(SSP_OFF_MODE, 32'h2);
    chk("mark", 32'h1, 32'(ctrl.mark_mode));
    wr(SSP_OFF_MODE, 32'h3);
    chk("mark", 32'h1, 32'(ctrl.mark_mode));
    wr(SSP_OFF_MODE, 32'h1);
    chk("mark", 32'h0, 32'(ctrl.mark_mode));
    wr(SSP_OFF_DRIVE, 32'h2);
    wr(SSP_OFF_DRIVE, 32'h0);
    chk("4q", 32'h0, 32'(ctrl.four_quadrant));
    wr(SSP_OFF_DRIVE, 32'h1);
    chk("4q", 32'h1, 32'(ctrl.four_quadrant));
    wr(SSP_OFF_ENTRY, 32'h1);
    wr(SSP_OFF_ENTRY, 32'h2);
    chk("bin", 32'h1, 32'(ctrl.binary_entry));
    wr(SSP_OFF_LOOP, 32'h0);
    chk("loop", 32'h0, 32'(ctrl.loop_on));
    wr(SSP_OFF_LDIR, 32'h1);
    wr(SSP_OFF_CDIR, 32'h1);
    chk("dirs", 32'h3, {30'h0, ctrl.line_ccw, ctrl.carriage_ccw});
    wr(SSP_OFF_NODE, 32'h63);
    wr(SSP_OFF_NODE, 32'h64);
    wr(SSP_OFF_NODE, 32'hA);
    rd(SSP_OFF_NODE, 32'h63);
    wr(SSP_OFF_NODE, 32'hB);
    chk("node", 32'hB, 32'(node_number));
    for (int i = 0; i < 7; i++) begin
      wr(SSP_OFF_RATE, 32'(i));
      chk("baud", baud_t[i], 32'(baud_rate));
    end
    wr(SSP_OFF_RATE, 32'h7);
    chk("baud", 32'h9600, 32'(baud_rate));
    for (int i = 0; i < 10; i++) begin
      wr(SSP_OFF_FRAME, 32'(i));
      chk("frame", frm_t[i], 32'(frame));
      chk("char bits", bits_t[i], 32'(char_bits));
    end
    wr(SSP_OFF_FRAME, 32'hA);
    chk("frame", 32'hD, 32'(frame));
    wr(SSP_OFF_TOFS, 32'hFFFFFF9D);
    wr(SSP_OFF_TOFS, 32'hFFFFFF9C);
    wr(SSP_OFF_TOFS, 32'h0000009D);
    chk("tofs", 32'h9D, {24'h0, total_offset_mv});
    wr(SSP_OFF_COFS, 32'h63);
    wr(SSP_OFF_COFS, 32'h64);
    chk("cofs", 32'h63, {24'h0, corr_offset_mv});
    wr(SSP_OFF_CGAIN, 32'hFFFF);
    chk("cgain", 32'hFFFF, 32'(corr_gain));
    wr(SSP_OFF_FGAIN, 32'hF423F);
    wr(SSP_OFF_FGAIN, 32'hF4240);
    chk("fgain", 32'hF423F, 32'(ff_gain));
    wr(4'hD, 32'h1);
    rd(4'hD, 32'h0);
    // second reset in mid-run must restore the defaults
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("fgain rst", 32'h0, 32'(ff_gain));
    rd(SSP_OFF_RATE, 32'h0);
    wrap_up;
  end
endmodule
